/* eeprom_slave_defs.vh */
// constants for the two-wire serial eeprom slave
`ifndef EEPROM_SLAVE_DEFS_VH
`define EEPROM_SLAVE_DEFS_VH

// ----------------------------------------------------------------
// device address word
// ----------------------------------------------------------------
`define DEV_TYPE_CODE     4'ha
`define DEV_TYPE_MSB      7
`define DEV_TYPE_LSB      4
`define DEV_SEL_MSB       3
`define DEV_SEL_LSB       1
`define DEV_RW_BIT        0

// ----------------------------------------------------------------
// density variants and array geometry
// ----------------------------------------------------------------
`define SIZE_2K           2'h0
`define SIZE_4K           2'h1
`define SIZE_8K           2'h2
`define SIZE_16K          2'h3
`define ADDR_W            11
`define MEM_BYTES         2048
`define ADDR_MASK_2K      11'h0ff
`define ADDR_MASK_4K      11'h1ff
`define ADDR_MASK_8K      11'h3ff
`define ADDR_MASK_16K     11'h7ff
`define PAGE_MASK_2K      11'h007
`define PAGE_MASK_BIG     11'h00f
`define PAGE_BYTES        16

// ----------------------------------------------------------------
// write buffer and timing
// ----------------------------------------------------------------
`define FIFO_DEPTH        8
`define FIFO_WIDTH        19
`define CLK_PERIOD_NS     20
`define PROG_INTERVAL_NS  5000000
`define PROG_CYCLES       (`PROG_INTERVAL_NS / `CLK_PERIOD_NS)
`define BIT_ACK           4'h8

`endif

/* eeprom_slave.v */
// two-wire serial eeprom slave: protocol engine, write fifo, array
`timescale 1ns/1ps
`include "eeprom_slave_defs.vh"

// ----------------------------------------------------------------
// write fifo
// ----------------------------------------------------------------
module write_fifo #(
	parameter WIDTH = `FIFO_WIDTH,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW    = 3
) (
	input  wire             clk_sys,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            do_push;
	wire            do_pop;

	// full when pointers differ only in the wrap bit
	assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = store[rd_ptr[AW-1:0]];
	assign do_push   = in_valid & in_ready;
	assign do_pop    = out_valid & out_ready;

	// pointer update
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

	// storage carries no reset, only data
	always @(posedge clk_sys) begin
		if (do_push)
			store[wr_ptr[AW-1:0]] <= in_data;
	end
endmodule

module eeprom_slave #(
	parameter integer PROG_CYCLES = `PROG_CYCLES
) (
	input  wire       clk_sys,
	input  wire       rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire       chip_select_pin_upper,
	input  wire       chip_select_pin_middle,
	input  wire       chip_select_pin_lower,
	input  wire [1:0] size_sel,
	output reg        standby,
	output reg        program_busy
);
	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_DADDR = 6'h02;
	localparam [5:0] ST_WADDR = 6'h04;
	localparam [5:0] ST_WDATA = 6'h08;
	localparam [5:0] ST_RDATA = 6'h10;
	localparam [5:0] ST_WAIT  = 6'h20;

	// ------------------------------------------------------------
	// input synchronisers and edge detection
	// ------------------------------------------------------------
	reg        scl_s1, scl_s2, scl_d;
	reg        sda_s1, sda_s2, sda_d;
	reg [2:0]  cs_s1, cs_s2;
	reg [1:0]  size_s1, size_s2;
	wire       scl_rise, scl_fall, start_det, stop_det;

	// two flops on every outside level; the first is read only here
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_s1  <= 1'b1;
			scl_s2  <= 1'b1;
			scl_d   <= 1'b1;
			sda_s1  <= 1'b1;
			sda_s2  <= 1'b1;
			sda_d   <= 1'b1;
			cs_s1   <= 3'h0;
			cs_s2   <= 3'h0;
			size_s1 <= 2'h0;
			size_s2 <= 2'h0;
		end else begin
			scl_s1  <= scl_in;
			scl_s2  <= scl_s1;
			scl_d   <= scl_s2;
			sda_s1  <= sda_in;
			sda_s2  <= sda_s1;
			sda_d   <= sda_s2;
			cs_s1   <= {chip_select_pin_upper, chip_select_pin_middle,
				chip_select_pin_lower};
			cs_s2   <= cs_s1;
			size_s1 <= size_sel;
			size_s2 <= size_s1;
		end
	end

	assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign scl_rise  = scl_s2 & ~scl_d;
	assign scl_fall  = ~scl_s2 & scl_d;

	// ------------------------------------------------------------
	// geometry per variant
	// ------------------------------------------------------------
	reg [`ADDR_W-1:0] addr_mask;
	reg [`ADDR_W-1:0] page_mask;
	reg               cs_match;
	reg [7:0]         shift;

	always @* begin
		addr_mask = `ADDR_MASK_16K;
		page_mask = `PAGE_MASK_BIG;
		cs_match  = 1'b1;
		case (size_s2)
		`SIZE_2K: begin
			addr_mask = `ADDR_MASK_2K;
			page_mask = `PAGE_MASK_2K;
			cs_match  = shift[`DEV_SEL_MSB:`DEV_SEL_LSB] == cs_s2;
		end
		`SIZE_4K: begin
			addr_mask = `ADDR_MASK_4K;
			cs_match  = shift[3:2] == cs_s2[2:1];
		end
		`SIZE_8K: begin
			addr_mask = `ADDR_MASK_8K;
			cs_match  = shift[3] == cs_s2[2];
		end
		default: begin
			addr_mask = `ADDR_MASK_16K;
			cs_match  = 1'b1;
		end
		endcase
	end

	// ------------------------------------------------------------
	// array, page latch and fifo
	// ------------------------------------------------------------
	reg  [7:0]            mem [0:`MEM_BYTES-1];
	reg  [7:0]            page_data [0:`PAGE_BYTES-1];
	reg  [`PAGE_BYTES-1:0] page_valid;
	reg  [`ADDR_W-1:0]    page_base;
	reg  [`ADDR_W-1:0]    addr_cnt;
	reg                   push;
	wire                  fifo_ready;
	wire [`FIFO_WIDTH-1:0] fifo_out;
	wire                  fifo_valid;
	reg  [17:0]           prog_cnt;
	wire                  commit;
	wire [`ADDR_W-1:0]    wr_next;
	wire [`ADDR_W-1:0]    rd_next;
	integer               i;

	// low bits wrap within the page
	assign wr_next = (addr_cnt & ~page_mask)
		| ((addr_cnt + 1'b1) & page_mask);
	// read wraps over the whole array
	assign rd_next = (addr_cnt + 1'b1) & addr_mask;
	// commit waits for the fifo to drain so no byte is dropped
	assign commit  = program_busy & (prog_cnt == 18'h00000) & ~fifo_valid;

	write_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_data   ({addr_cnt, shift}),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (~commit)
	);

	// page latch fills from fifo; commit writes latched bytes
	always @(posedge clk_sys) begin
		if (fifo_valid & ~commit) begin
			page_data[fifo_out[11:8] & page_mask[3:0]] <= fifo_out[7:0];
			page_base <= fifo_out[18:8] & ~page_mask;
		end
		if (commit) begin
			for (i = 0; i < `PAGE_BYTES; i = i + 1) begin
				if (page_valid[i])
					mem[page_base | i[`ADDR_W-1:0]] <= page_data[i];
			end
		end
	end

	// valid flags of the page latch
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			page_valid <= {`PAGE_BYTES{1'b0}};
		end else if (commit) begin
			page_valid <= {`PAGE_BYTES{1'b0}};
		end else if (fifo_valid) begin
			page_valid[fifo_out[11:8] & page_mask[3:0]] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	reg [5:0] state;
	reg [3:0] bit_cnt;
	reg       ack_phase;
	reg       rw_read;
	reg [2:0] hi_bits;
	reg       master_ack;
	reg [7:0] tx;

	// one process owns state, shifter and the data driver
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state        <= ST_IDLE;
			bit_cnt      <= 4'h0;
			ack_phase    <= 1'b0;
			rw_read      <= 1'b0;
			hi_bits      <= 3'h0;
			master_ack   <= 1'b0;
			tx           <= 8'h00;
			shift        <= 8'h00;
			addr_cnt     <= {`ADDR_W{1'b0}};
			sda_oe       <= 1'b0;
			sda_out      <= 1'b0;
			push         <= 1'b0;
			program_busy <= 1'b0;
			prog_cnt     <= 18'h00000;
			standby      <= 1'b1;
		end else begin
			push    <= 1'b0;
			// standby once idle and nothing pending
			standby <= (state == ST_IDLE) & ~program_busy;
			if (program_busy) begin
				if (prog_cnt != 18'h00000)
					prog_cnt <= prog_cnt - 1'b1;
				else if (~fifo_valid)
					program_busy <= 1'b0;
			end
			if (start_det) begin
				state     <= ST_DADDR;
				bit_cnt   <= 4'h0;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
			end else if (stop_det) begin
				if ((state == ST_WDATA) & ~program_busy
						& (fifo_valid | push | (|page_valid))) begin
					program_busy <= 1'b1;
					prog_cnt     <= PROG_CYCLES[17:0];
				end
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise & (state != ST_IDLE)
					& (state != ST_WAIT)) begin
				if (bit_cnt < `BIT_ACK) begin
					shift   <= {shift[6:0], sda_s2};
					bit_cnt <= bit_cnt + 1'b1;
				end else if (state == ST_RDATA) begin
					master_ack <= ~sda_s2;
				end
			end else if (scl_fall & (state != ST_IDLE)
					& (state != ST_WAIT)) begin
				if (~ack_phase & (bit_cnt == `BIT_ACK)) begin
					ack_phase <= 1'b1;
					case (state)
					ST_DADDR: begin
						if ((shift[`DEV_TYPE_MSB:`DEV_TYPE_LSB]
								== `DEV_TYPE_CODE)
								& cs_match & ~program_busy) begin
							sda_oe  <= 1'b1;
							hi_bits <= shift[`DEV_SEL_MSB:`DEV_SEL_LSB];
							rw_read <= shift[`DEV_RW_BIT];
						end else begin
							state <= ST_IDLE;
						end
					end
					ST_WADDR: begin
						sda_oe   <= 1'b1;
						addr_cnt <= {hi_bits, shift} & addr_mask;
					end
					ST_WDATA: begin
						if (fifo_ready) begin
							sda_oe <= 1'b1;
							push   <= 1'b1;
						end else begin
							state <= ST_WAIT;
						end
					end
					default: begin
						// release for the controller ack
						sda_oe <= 1'b0;
					end
					endcase
				end else if (ack_phase) begin
					ack_phase <= 1'b0;
					bit_cnt   <= 4'h0;
					sda_oe    <= 1'b0;
					case (state)
					ST_DADDR: begin
						if (rw_read) begin
							state    <= ST_RDATA;
							tx       <= {mem[addr_cnt][6:0], 1'b0};
							sda_oe   <= ~mem[addr_cnt][7];
							addr_cnt <= rd_next;
						end else begin
							state <= ST_WADDR;
						end
					end
					ST_WADDR: state <= ST_WDATA;
					ST_WDATA: addr_cnt <= wr_next;
					ST_RDATA: begin
						if (master_ack) begin
							tx       <= {mem[addr_cnt][6:0], 1'b0};
							sda_oe   <= ~mem[addr_cnt][7];
							addr_cnt <= rd_next;
						end else begin
							state <= ST_WAIT;
						end
					end
					default: state <= ST_IDLE;
					endcase
				end else if (state == ST_RDATA) begin
					// drive only low, change on fall
					if (bit_cnt == `BIT_ACK) begin
						sda_oe <= 1'b0;
					end else begin
						sda_oe <= ~tx[7];
						tx     <= {tx[6:0], 1'b0};
					end
				end
			end
		end
	end
endmodule

/* eeprom_slave_checker.sv */
// port assertions for the eeprom slave
`timescale 1ns/1ps
module eeprom_slave_checker #(
	parameter integer PROG_CYCLES = 50
) (
	input wire clk_sys,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire standby,
	input wire program_busy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	reg [31:0] busy_len;
	// cycles spent programming so far
	always @(posedge clk_sys or posedge rst) begin
		if (rst)
			busy_len <= 32'h0;
		else if (!program_busy)
			busy_len <= 32'h0;
		else
			busy_len <= busy_len + 32'h1;
	end
	sda_low_a: assert property (sda_out == 1'b0)
		else $error("data output driven high");
	oe_move_a: assert property (!$stable(sda_oe) |-> !scl_in)
		else $error("data drive moved while clock high");
	oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe[*8])
		else $error("data drive shorter than a bit");
	idle_quiet_a: assert property (sda_oe |-> !standby)
		else $error("data driven while idle");
	busy_quiet_a: assert property (program_busy |-> !sda_oe && !standby)
		else $error("active while programming");
	busy_min_a: assert property ($fell(program_busy) |->
		$past(busy_len) >= PROG_CYCLES - 1)
		else $error("program interval too short");
	busy_max_a: assert property (program_busy |->
		busy_len < PROG_CYCLES + 8)
		else $error("program interval too long");
	busy_end_a: assert property ($fell(program_busy) |-> ##[0:1] standby)
		else $error("no standby after program");
	stop_idle_a: assert property (scl_in && $rose(sda_in) && !program_busy
		|-> ##[1:6] (standby || program_busy))
		else $error("no standby after stop");
endmodule

bind eeprom_slave eeprom_slave_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
	.clk_sys      (clk_sys),
	.rst          (rst),
	.scl_in       (scl_in),
	.sda_in       (sda_in),
	.sda_out      (sda_out),
	.sda_oe       (sda_oe),
	.standby      (standby),
	.program_busy (program_busy)
);

/* bus_controller_model.sv */
// two-wire bus controller model
`timescale 1ns/1ps
module bus_controller_model (
	input  wire clk_sys,
	input  wire sda,
	output reg  scl,
	output reg  pull_low
);
	// idle bus: clock parked high, data released
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	// quarter link period, launched just after an edge
	task quarter;
	begin
		repeat (2) @(posedge clk_sys);
		#1;
	end
	endtask
	task xfer_bit(input b, output reg r);
	begin
		scl = 1'b0;
		quarter;
		pull_low = ~b;
		quarter;
		scl = 1'b1;
		quarter;
		r = sda;
		quarter;
	end
	endtask
	task cond(input stop);
	begin
		scl = 1'b0;
		quarter;
		pull_low = stop;
		quarter;
		scl = 1'b1;
		quarter;
		pull_low = ~stop;
		quarter;
	end
	endtask
	task send_byte(input [7:0] d, output reg ack);
		integer i;
		reg r;
	begin
		for (i = 7; i >= 0; i = i - 1)
			xfer_bit(d[i], r);
		xfer_bit(1'b1, r);
		ack = ~r;
	end
	endtask
	task get_byte(input more, output reg [7:0] d);
		integer i;
		reg r;
	begin
		for (i = 7; i >= 0; i = i - 1) begin
			xfer_bit(1'b1, r);
			d[i] = r;
		end
		xfer_bit(~more, r);
	end
	endtask
	task recover;
		reg r;
	begin
		repeat (9) xfer_bit(1'b1, r);
		cond(1'b0);
	end
	endtask
endmodule

/* two_wire_serial_eeprom_slave_test.sv */
// self-checking bench for the eeprom slave
`timescale 1ns/1ps
module two_wire_serial_eeprom_slave_test;
	localparam integer PROG = 200;
	reg         clk_sys;
	reg         rst;
	reg         cs_u;
	reg         cs_m;
	reg         cs_l;
	reg  [1:0]  size_sel;
	wire        scl;
	wire        pull_low;
	wire        sda_out;
	wire        sda_oe;
	wire        standby;
	wire        program_busy;
	reg  [7:0]  mem [0:2047];
	integer     mismatches;
	integer     checks_done;
	integer     seed;
	integer     sz;
	integer     i;
	reg         ack;
	reg  [7:0]  d;
	reg  [10:0] mask;
	reg  [10:0] base;
	reg  [10:0] a;
	reg  [10:0] pm;
	// pull-up wins unless someone sinks the line
	wire        sda_line = ~(pull_low | sda_oe);

	always #10 clk_sys = ~clk_sys;

	eeprom_slave #(.PROG_CYCLES(PROG)) dut (
		.clk_sys                (clk_sys),
		.rst                    (rst),
		.scl_in                 (scl),
		.sda_in                 (sda_line),
		.sda_out                (sda_out),
		.sda_oe                 (sda_oe),
		.chip_select_pin_upper  (cs_u),
		.chip_select_pin_middle (cs_m),
		.chip_select_pin_lower  (cs_l),
		.size_sel               (size_sel),
		.standby                (standby),
		.program_busy           (program_busy)
	);
	bus_controller_model ctl (
		.clk_sys  (clk_sys),
		.sda      (sda_line),
		.scl      (scl),
		.pull_low (pull_low)
	);

	function [7:0] dev_word(input [10:0] adr, input rw);
	begin
		case (size_sel)
		2'h0: dev_word = {4'ha, cs_u, cs_m, cs_l, rw};
		2'h1: dev_word = {4'ha, cs_u, cs_m, adr[8], rw};
		2'h2: dev_word = {4'ha, cs_u, adr[9:8], rw};
		default: dev_word = {4'ha, adr[10:8], rw};
		endcase
	end
	endfunction

	task check(input [10:0] seen, input [10:0] exp);
	begin
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task complete_run;
	begin
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	// start a write and load the word address
	task open_at(input [10:0] adr);
	begin
		ctl.cond(1'b0);
		ctl.send_byte(dev_word(adr, 1'b0), ack);
		check(ack, 1'b1);
		ctl.send_byte(adr[7:0], ack);
		check(ack, 1'b1);
	end
	endtask

	// bounded wait for the program interval to end
	task wait_prog;
		integer k;
	begin
		k = 0;
		while (program_busy !== 1'b0 && k < PROG + 20) begin
			@(posedge clk_sys);
			k = k + 1;
		end
		@(posedge clk_sys);
		#1;
		check(k < PROG + 20, 1'b1);
		check(standby, 1'b1);
	end
	endtask

	// watchdog: several times the expected run length
	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches = mismatches + 1;
		complete_run;
	end

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		{cs_u, cs_m, cs_l} = 3'h0;
		size_sel = 2'h0;
		seed = 32'h944e8bb4;
		mismatches = 0;
		checks_done = 0;
		repeat (10) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		check(standby, 1'b1);
		check(sda_oe, 1'b0);
		repeat (6) @(posedge clk_sys);
		#1;
		ctl.recover;
		// byte write at zero gives the read wrap a known byte
		d = $random(seed);
		mem[0] = d;
		open_at(11'h0);
		ctl.send_byte(d, ack);
		check(ack, 1'b1);
		ctl.cond(1'b1);
		repeat (8) @(posedge clk_sys);
		#1;
		check(program_busy, 1'b1);
		wait_prog;
		for (sz = 0; sz < 4; sz = sz + 1) begin
			size_sel = sz;
			cs_u = $random(seed);
			cs_m = $random(seed);
			cs_l = $random(seed);
			repeat (4) @(posedge clk_sys);
			#1;
			mask = (11'h100 << sz) - 11'h1;
			pm = (sz == 0) ? 11'h7 : 11'hf;
			base = mask & ~pm;
			// refused words: upper pin wrong, then type wrong
			if (sz < 3) begin
				ctl.cond(1'b0);
				ctl.send_byte(dev_word(base, 1'b0) ^ 8'h08, ack);
				check(ack, 1'b0);
			end
			ctl.cond(1'b0);
			ctl.send_byte(dev_word(base, 1'b0) ^ 8'h10, ack);
			check(ack, 1'b0);
			repeat (4) @(posedge clk_sys);
			#1;
			check(standby, 1'b1);
			// top page written two bytes past its end
			a = $random(seed) & pm;
			open_at(base | a);
			for (i = 0; i < pm + 3; i = i + 1) begin
				d = $random(seed);
				mem[base | ((a + i) & pm)] = d;
				ctl.send_byte(d, ack);
				check(ack, 1'b1);
			end
			ctl.cond(1'b1);
			ctl.cond(1'b0);
			ctl.send_byte(dev_word(base, 1'b0), ack);
			check(ack, 1'b0);
			wait_prog;
			open_at(base);
			ctl.cond(1'b0);
			ctl.send_byte(dev_word(base, 1'b1), ack);
			check(ack, 1'b1);
			for (i = 0; i <= pm; i = i + 1) begin
				ctl.get_byte(i < pm, d);
				check(d, mem[base | i]);
			end
			ctl.cond(1'b1);
			// counter rolled from array end to zero
			ctl.cond(1'b0);
			ctl.send_byte(dev_word(11'h0, 1'b1), ack);
			check(ack, 1'b1);
			ctl.get_byte(1'b0, d);
			check(d, mem[0]);
			ctl.cond(1'b1);
		end
		complete_run;
	end
endmodule
